// File: logic/ecc_i2c_pkg.sv
// shared constants, types and states of the ecc register two-wire slave
package ecc_i2c_pkg;
   // slave address byte layout
   localparam logic [3:0] DEVICE_TYPE     = 4'h3;
   localparam int         TYPE_MSB        = 7;
   localparam int         TYPE_LSB        = 4;
   localparam int         SELECT_BIT      = 1;
   localparam int         DIR_BIT         = 0;
   // register address layout and register pointer
   localparam int         PTR_MSB         = 2;
   localparam logic [2:0] FIRST_INDEX     = 3'h0;
   localparam logic [2:0] LAST_INDEX      = 3'h5;
   localparam logic [2:0] WRITABLE_INDEX  = 3'h5;
   localparam logic [2:0] PTR_RESET       = 3'h0;
   // reset values and bit counting
   localparam logic [7:0] WRITABLE_RESET  = 8'h00;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

   // the five read-only registers as delivered by the ecc core
   typedef struct packed {
      logic [7:0] reg4;
      logic [7:0] reg3;
      logic [7:0] reg2;
      logic [7:0] reg1;
      logic [7:0] reg0;
   } ecc_readonly_registers_t;

   // link states, gray coded along the write path; the step from ST_ACK_ADR to ST_RDATA changes three bits
   typedef enum logic [3:0] {
      ST_IDLE    = 4'h0,
      ST_ADDR    = 4'h1,
      ST_ACK_ADR = 4'h3,
      ST_REGADDR = 4'h2,
      ST_ACK_REG = 4'h6,
      ST_WDATA   = 4'h7,
      ST_ACK_WR  = 4'h5,
      ST_RDATA   = 4'h4,
      ST_RACK    = 4'hC,
      ST_IGNORE  = 4'hD
   } link_state_t;
endpackage

// File: logic/sync_filter.sv
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module sync_filter (
   // clock and reset of the receiving domain
   input  wire logic clk,
   input  wire logic rst,
   // asynchronous level in, filtered level out
   input  wire logic d,
   output logic      q
);
   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= 1'b1;
         stage2 <= 1'b1;
         stage3 <= 1'b1;
         q      <= 1'b1;
      end else begin
         stage1 <= d;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            q <= stage3;
         end
      end
   end
endmodule

// File: logic/ecc_register_two_wire_slave.sv
// two-wire slave giving a bus master access to the six ecc registers
`timescale 1ns/1ps
module ecc_register_two_wire_slave (
   // core clock domain
   input  wire logic                                 core_clk,
   input  wire logic                                 rst,
   // register contents on the core side
   input  wire ecc_i2c_pkg::ecc_readonly_registers_t eccReadonlyRegisters,
   output logic [7:0]                                eccWritableSetting,
   // link clock domain
   input  wire logic                                 linkClk,
   // two-wire pins and device select strap
   input  wire logic                                 scl,
   input  wire logic                                 sdaIn,
   output logic                                      sdaOut,
   output logic                                      sdaDriveN,
   input  wire logic                                 deviceSelectPin
);
   // ---------------- core domain ----------------
   logic [7:0] shadow [0:5];
   logic       snapReq;
   logic       snapAckCore;
   logic       writeTglCore;
   logic       writeTglPrev;
   logic       linkRstMeta;
   logic       linkRst;
   logic [7:0] writeData;
   logic       writeTgl;
   logic       snapAck;
   logic       snapReqLink;

   sync_filter ackSync (
      .clk (core_clk),
      .rst (rst),
      .d   (snapAck),
      .q   (snapAckCore)
   );

   sync_filter writeSync (
      .clk (core_clk),
      .rst (rst),
      .d   (writeTgl),
      .q   (writeTglCore)
   );

   wire snapDue   = (snapAckCore == snapReq);
   wire writeSeen = (writeTglCore != writeTglPrev);

   // register five lives here so the core sees it without a crossing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         eccWritableSetting <= ecc_i2c_pkg::WRITABLE_RESET;
         // matches the synchroniser's reset level, so no false write follows reset
         writeTglPrev       <= 1'h1;
      end else begin
         writeTglPrev <= writeTglCore;
         if (writeSeen) begin
            eccWritableSetting <= writeData;
         end
      end
   end

   // shadow is only rewritten after the link has taken the last copy
   always_ff @(posedge core_clk) begin
      if (rst) begin
         snapReq <= 1'b0;
         for (int i = 0; i < 6; i++) begin
            shadow[i] <= ecc_i2c_pkg::WRITABLE_RESET;
         end
      end else if (snapDue) begin
         snapReq   <= ~snapReq;
         shadow[0] <= eccReadonlyRegisters.reg0;
         shadow[1] <= eccReadonlyRegisters.reg1;
         shadow[2] <= eccReadonlyRegisters.reg2;
         shadow[3] <= eccReadonlyRegisters.reg3;
         shadow[4] <= eccReadonlyRegisters.reg4;
         shadow[5] <= eccWritableSetting;
      end
   end

   // ---------------- link domain ----------------
   always_ff @(posedge linkClk) begin
      linkRstMeta <= rst;
      linkRst     <= linkRstMeta;
   end

   logic sclQ;
   logic sdaQ;
   logic selQ;
   logic sclPrev;
   logic sdaPrev;

   sync_filter sclSync (
      .clk (linkClk),
      .rst (linkRst),
      .d   (scl),
      .q   (sclQ)
   );

   sync_filter sdaSync (
      .clk (linkClk),
      .rst (linkRst),
      .d   (sdaIn),
      .q   (sdaQ)
   );

   sync_filter selSync (
      .clk (linkClk),
      .rst (linkRst),
      .d   (deviceSelectPin),
      .q   (selQ)
   );

   sync_filter reqSync (
      .clk (linkClk),
      .rst (linkRst),
      .d   (snapReq),
      .q   (snapReqLink)
   );

   logic [7:0]               localCopy [0:5];
   ecc_i2c_pkg::link_state_t state;
   logic [7:0]               rxShift;
   logic [7:0]               txShift;
   logic [3:0]               bitCount;
   logic [2:0]               pointer;
   logic                     readDir;
   logic                     masterAck;

   function automatic logic [7:0] pick(input logic [2:0] idx, input logic [7:0] r0,
                                       input logic [7:0] r1, input logic [7:0] r2,
                                       input logic [7:0] r3, input logic [7:0] r4,
                                       input logic [7:0] r5);
      case (idx)
         3'h0:    pick = r0;
         3'h1:    pick = r1;
         3'h2:    pick = r2;
         3'h3:    pick = r3;
         3'h4:    pick = r4;
         3'h5:    pick = r5;
         default: pick = ecc_i2c_pkg::UNMAPPED_READ;
      endcase
   endfunction

   wire sclRise   = sclQ & ~sclPrev;
   wire sclFall   = ~sclQ & sclPrev;
   wire startCond = sclQ & sclPrev & sdaPrev & ~sdaQ;
   wire stopCond  = sclQ & sclPrev & ~sdaPrev & sdaQ;
   wire byteIn    = (bitCount == ecc_i2c_pkg::BITS_PER_BYTE);
   wire [7:0] curByte = pick(pointer, localCopy[0], localCopy[1], localCopy[2],
                             localCopy[3], localCopy[4], localCopy[5]);
   wire addrMatch = (rxShift[ecc_i2c_pkg::TYPE_MSB:ecc_i2c_pkg::TYPE_LSB]
                     == ecc_i2c_pkg::DEVICE_TYPE)
                    && (rxShift[ecc_i2c_pkg::SELECT_BIT] == selQ);
   wire [2:0] nextPointer = (pointer >= ecc_i2c_pkg::LAST_INDEX) ?
                            ecc_i2c_pkg::FIRST_INDEX : pointer + 3'h1;

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         snapAck <= 1'b0;
      end else if (snapReqLink != snapAck) begin
         snapAck <= snapReqLink;
         for (int i = 0; i < 6; i++) begin
            localCopy[i] <= shadow[i];
         end
      end
   end

   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= sclQ;
         sdaPrev <= sdaQ;
      end
   end

   // the pin is only ever pulled low; sdaDriveN low means pulling
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         state     <= ecc_i2c_pkg::ST_IDLE;
         rxShift   <= 8'h00;
         txShift   <= 8'h00;
         bitCount  <= ecc_i2c_pkg::BIT_COUNT_RESET;
         pointer   <= ecc_i2c_pkg::PTR_RESET;
         readDir   <= 1'b0;
         masterAck <= 1'b0;
         sdaOut    <= 1'b0;
         sdaDriveN <= 1'b1;
         writeData <= ecc_i2c_pkg::WRITABLE_RESET;
         writeTgl  <= 1'h1;
      end else if (startCond) begin
         // a start aborts any transfer, but a data byte already received for register five is still written
         state     <= ecc_i2c_pkg::ST_ADDR;
         bitCount  <= ecc_i2c_pkg::BIT_COUNT_RESET;
         sdaDriveN <= 1'b1;
      end else if (stopCond) begin
         state     <= ecc_i2c_pkg::ST_IDLE;
         sdaDriveN <= 1'b1;
      end else if (sclRise) begin
         if (state == ecc_i2c_pkg::ST_RACK) begin
            masterAck <= ~sdaQ;
            pointer   <= nextPointer;
         end else begin
            rxShift <= {rxShift[6:0], sdaQ};
         end
         bitCount <= bitCount + 4'h1;
      end else if (sclFall) begin
         case (state)
            ecc_i2c_pkg::ST_ADDR: begin
               if (byteIn) begin
                  state     <= addrMatch ? ecc_i2c_pkg::ST_ACK_ADR : ecc_i2c_pkg::ST_IGNORE;
                  sdaDriveN <= ~addrMatch;
                  readDir   <= rxShift[ecc_i2c_pkg::DIR_BIT];
               end
            end
            ecc_i2c_pkg::ST_ACK_ADR: begin
               bitCount <= ecc_i2c_pkg::BIT_COUNT_RESET;
               if (readDir) begin
                  state     <= ecc_i2c_pkg::ST_RDATA;
                  txShift   <= {curByte[6:0], 1'b0};
                  sdaDriveN <= curByte[7];
               end else begin
                  state     <= ecc_i2c_pkg::ST_REGADDR;
                  sdaDriveN <= 1'b1;
               end
            end
            ecc_i2c_pkg::ST_REGADDR: begin
               if (byteIn) begin
                  state     <= ecc_i2c_pkg::ST_ACK_REG;
                  pointer   <= rxShift[ecc_i2c_pkg::PTR_MSB:0];
                  sdaDriveN <= 1'b0;
               end
            end
            ecc_i2c_pkg::ST_ACK_REG: begin
               state     <= ecc_i2c_pkg::ST_WDATA;
               bitCount  <= ecc_i2c_pkg::BIT_COUNT_RESET;
               sdaDriveN <= 1'b1;
            end
            ecc_i2c_pkg::ST_WDATA: begin
               if (byteIn) begin
                  state     <= ecc_i2c_pkg::ST_ACK_WR;
                  sdaDriveN <= 1'b0;
                  if (pointer == ecc_i2c_pkg::WRITABLE_INDEX) begin
                     writeData <= rxShift;
                     writeTgl  <= ~writeTgl;
                  end
               end
            end
            ecc_i2c_pkg::ST_ACK_WR: begin
               // a second data byte is neither acked nor stored
               state     <= ecc_i2c_pkg::ST_IGNORE;
               sdaDriveN <= 1'b1;
            end
            ecc_i2c_pkg::ST_RDATA: begin
               if (byteIn) begin
                  state     <= ecc_i2c_pkg::ST_RACK;
                  sdaDriveN <= 1'b1;
               end else begin
                  txShift   <= {txShift[6:0], 1'b0};
                  sdaDriveN <= txShift[7];
               end
            end
            ecc_i2c_pkg::ST_RACK: begin
               bitCount <= ecc_i2c_pkg::BIT_COUNT_RESET;
               if (masterAck) begin
                  state     <= ecc_i2c_pkg::ST_RDATA;
                  txShift   <= {curByte[6:0], 1'b0};
                  sdaDriveN <= curByte[7];
               end else begin
                  state     <= ecc_i2c_pkg::ST_IGNORE;
                  sdaDriveN <= 1'b1;
               end
            end
            ecc_i2c_pkg::ST_IDLE,
            ecc_i2c_pkg::ST_IGNORE: begin
               sdaDriveN <= 1'b1;
            end
            default: begin
               state     <= ecc_i2c_pkg::ST_IDLE;
               sdaDriveN <= 1'b1;
            end
         endcase
      end
   end
endmodule

// File: verif/ecc_slave_properties.sv
// port checks for the ecc register two-wire slave
`timescale 1ns/1ps
module ecc_slave_properties (
   // core domain
   input wire logic                                 core_clk,
   input wire logic                                 rst,
   input wire ecc_i2c_pkg::ecc_readonly_registers_t eccReadonlyRegisters,
   input wire logic [7:0]                           eccWritableSetting,
   // link domain
   input wire logic                                 linkClk,
   input wire logic                                 scl,
   input wire logic                                 sdaIn,
   input wire logic                                 sdaOut,
   input wire logic                                 sdaDriveN,
   input wire logic                                 deviceSelectPin
);
   AST_OPEN_DRAIN: assert property (@(posedge linkClk) disable iff (rst)
      sdaOut == 1'h0) else $error("sda output value not low");
   AST_RESET_SETTING: assert property (@(posedge core_clk) disable iff (rst)
      $fell(rst) |-> eccWritableSetting == 8'h00) else $error("setting not cleared");
   AST_QUIET_AFTER_RESET: assert property (@(posedge core_clk) disable iff (rst)
      $fell(rst) |-> sdaDriveN [*8]) else $error("sda pulled right after reset");
   AST_CHANGE_SCL_LOW: assert property (@(posedge linkClk) disable iff (rst)
      $changed(sdaDriveN) |-> !scl && !$past(scl, 2)) else $error("sda moved near scl high");
   AST_PROMPT_ANSWER: assert property (@(posedge linkClk) disable iff (rst)
      $changed(sdaDriveN) |-> $past(scl, 12)) else $error("sda answer late after scl fall");
   AST_STABLE_SCL_HIGH: assert property (@(posedge linkClk) disable iff (rst)
      scl && $past(scl, 8) |-> $stable(sdaDriveN)) else $error("sda moved while scl high");
   AST_SETTING_AT_ACK: assert property (@(posedge core_clk) disable iff (rst)
      $changed(eccWritableSetting) |-> !sdaDriveN) else $error("setting moved outside ack");
   AST_RELEASE_BOUNDED: assert property (@(posedge linkClk) disable iff (rst)
      $fell(sdaDriveN) |-> ##[1:1000] sdaDriveN) else $error("sda held low too long");
endmodule
bind ecc_register_two_wire_slave ecc_slave_properties props_u (
   .core_clk(core_clk), .rst(rst), .eccReadonlyRegisters(eccReadonlyRegisters),
   .eccWritableSetting(eccWritableSetting), .linkClk(linkClk), .scl(scl), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaDriveN(sdaDriveN), .deviceSelectPin(deviceSelectPin));

// File: verif/ecc_master_model.sv
// behavioural two-wire bus master on the board side
`timescale 1ns/1ps
module ecc_master_model (
   // pacing reference
   input  wire logic clk,
   // bus lines; released sda reads the pull-up level
   output logic      scl,
   output logic      sdaDrive,
   input  wire logic sdaWire
);
   initial begin
      scl = 1'h1;
      sdaDrive = 1'h1;
   end
   // quarter bit of 300 ns, so scl stays high and low 600 ns each
   task automatic q();
      repeat (6) @(negedge clk);
   endtask
   // also serves as repeated start
   task automatic start();
      sdaDrive = 1'h1;
      q();
      scl = 1'h1;
      q();
      sdaDrive = 1'h0;
      q();
      scl = 1'h0;
      q();
   endtask
   task automatic stop();
      sdaDrive = 1'h0;
      q();
      scl = 1'h1;
      q();
      sdaDrive = 1'h1;
      q();
   endtask
   task automatic bitx(input logic b, output logic r);
      sdaDrive = b;
      q();
      scl = 1'h1;
      q();
      r = sdaWire;
      q();
      scl = 1'h0;
      q();
   endtask
   // eight bits then the ninth; reads send ff so the line stays released
   task automatic byte9(input logic [7:0] d, input logic a, output logic [7:0] r,
                        output logic ar);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r[i]);
      end
      bitx(a, ar);
   endtask
endmodule

// File: verif/ecc_register_two_wire_slave_bench.sv
// self-checking bench for the ecc register two-wire slave
`timescale 1ns/1ps
module ecc_register_two_wire_slave_bench;
   logic                                 core_clk;
   logic                                 rst;
   logic                                 linkClk;
   logic                                 deviceSelectPin;
   ecc_i2c_pkg::ecc_readonly_registers_t regs;
   logic [7:0]                           eccWritableSetting;
   logic                                 scl;
   logic                                 sdaDrive;
   logic                                 sdaOut;
   logic                                 sdaDriveN;
   logic                                 sdaWire;
   logic [7:0]                           rd;
   logic                                 ack;
   int                                   num_errors = 0;
   int                                   cmp_count = 0;

   // wired-and of master and slave with pull-up
   assign sdaWire = sdaDrive & (sdaDriveN | sdaOut);
   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      linkClk = 1'h0;
      #1.7;
      forever #3 linkClk = ~linkClk;
   end
   ecc_register_two_wire_slave dut_u (.core_clk(core_clk), .rst(rst),
      .eccReadonlyRegisters(regs), .eccWritableSetting(eccWritableSetting),
      .linkClk(linkClk), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaDriveN(sdaDriveN), .deviceSelectPin(deviceSelectPin));
   ecc_master_model m_u (.clk(core_clk), .scl(scl), .sdaDrive(sdaDrive), .sdaWire(sdaWire));

   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] d, input logic expAck);
      m_u.byte9(d, 1'h1, rd, ack);
      chk({7'h00, expAck}, {7'h00, ack});
   endtask
   task automatic rdb(input logic last, input logic [7:0] exp);
      m_u.byte9(8'hFF, last, rd, ack);
      chk(exp, rd);
   endtask
   task automatic results();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic t_address();
      logic [7:0] codes [3];
      codes = '{8'h72, 8'h30, 8'h3E};
      for (int i = 0; i < 3; i++) begin
         m_u.start();
         wr(codes[i], i < 2);
         m_u.stop();
      end
      // strap low: address bit one must now be low to be answered
      deviceSelectPin = 1'h0;
      m_u.start();
      wr(8'h30, 1'h0);
      m_u.stop();
      m_u.start();
      wr(8'h32, 1'h1);
      m_u.stop();
      deviceSelectPin = 1'h1;
   endtask
   // a second data byte must be refused and lost
   task automatic t_write();
      m_u.start();
      wr(8'h32, 1'h0);
      wr(8'hFD, 1'h0);
      wr(8'h3C, 1'h0);
      wr(8'hC3, 1'h1);
      m_u.stop();
      repeat (20) @(negedge core_clk);
      chk(8'h3C, eccWritableSetting);
   endtask
   task automatic t_random();
      m_u.start();
      wr(8'h32, 1'h0);
      wr(8'h02, 1'h0);
      wr(8'h11, 1'h0);
      m_u.start();
      wr(8'h33, 1'h0);
      rdb(1'h0, 8'h96);
      rdb(1'h1, 8'h5A);
      m_u.start();
      wr(8'h32, 1'h0);
      wr(8'h04, 1'h0);
      m_u.start();
      wr(8'h33, 1'h0);
      rdb(1'h0, 8'hE7);
      rdb(1'h0, 8'h3C);
      rdb(1'h1, 8'hA5);
      m_u.stop();
      chk(8'h3C, eccWritableSetting);
   endtask
   task automatic t_current();
      m_u.start();
      wr(8'h33, 1'h0);
      rdb(1'h1, 8'hC3);
      m_u.stop();
   endtask

   initial begin
      rst = 1'h1;
      deviceSelectPin = 1'h1;
      regs = '{8'hE7, 8'h5A, 8'h96, 8'hC3, 8'hA5};
      repeat (12) @(negedge core_clk);
      rst = 1'h0;
      repeat (30) @(negedge core_clk);
      chk(8'h00, eccWritableSetting);
      chk(8'h01, {7'h00, sdaDriveN});
      t_address();
      t_write();
      t_random();
      t_current();
      results();
   end
   // watchdog against a hung transfer
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      results();
   end
endmodule
